// [hdl/frame_crc8.sv]
// byte-serial eight-bit frame check generator
`timescale 1ns/1ps
`default_nettype none
module frame_crc8
  import otp_cfg_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic start, // restart for a new frame
  input wire logic [7:0] data, // frame byte
  input wire logic valid, // byte strobe
  input wire logic invert, // final inversion select
  input wire logic active, // check in use
  output logic [7:0] crc_raw, // running remainder
  output logic [7:0] crc_tx // value for the frame slot
);
  logic [7:0] next_crc;

  // one byte through x^8+x^4+x^3+x^2+1, msb first
  always_comb
  begin
    next_crc = crc_raw ^ data;
    for (int i = 0; i < 8; i++)
      next_crc = next_crc[7] ? ((next_crc << 1) ^ CRC_POLY)
                             : (next_crc << 1);
  end

  // running remainder
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      crc_raw <= CRC_INIT;
    else if (start)
      crc_raw <= CRC_INIT;
    else if (valid)
      crc_raw <= next_crc;
  end

  // slot value: final xor, or all zero while unused
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      crc_tx <= 8'h00;
    else if (!active)
      crc_tx <= 8'h00;
    else
      crc_tx <= crc_raw ^ (invert ? CRC_XOR_INV : CRC_XOR_PLAIN);
  end
endmodule : frame_crc8
`default_nettype wire

// [hdl/fuse_loader.sv]
// boot-time reader that walks the fuse image word by word
`timescale 1ns/1ps
`default_nettype none
module fuse_loader
  import otp_cfg_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  output logic fuse_req, // request to fuse array
  output logic [3:0] fuse_idx, // word being read
  input wire logic [7:0] fuse_rdata, // word from fuse array
  input wire logic fuse_ack, // word valid
  output logic load_we, // store pulse
  output logic [3:0] load_idx, // store index
  output logic [7:0] load_data, // store data
  output logic load_done // image complete
);
  load_state_t state;

  // ==========================================================
  // sequencer: one request per word, waits for each answer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= LD_IDLE;
      fuse_req <= 1'b0;
      fuse_idx <= 4'h0;
      load_we <= 1'b0;
      load_idx <= 4'h0;
      load_data <= FUSE_RESET;
      load_done <= 1'b0;
    end
    else
    begin
      load_we <= 1'b0;
      unique case (state)
        LD_IDLE:
        begin
          state <= LD_REQ;
        end
        LD_REQ:
        begin
          fuse_req <= 1'b1;
          state <= LD_WAIT;
        end
        LD_WAIT:
        begin
          if (fuse_ack)
          begin
            fuse_req <= 1'b0;
            load_we <= 1'b1;
            load_idx <= fuse_idx;
            load_data <= fuse_rdata;
            if (fuse_idx == FUSE_LAST)
              state <= LD_DONE;
            else
            begin
              fuse_idx <= fuse_idx + 4'h1;
              state <= LD_REQ;
            end
          end
        end
        LD_DONE:
        begin
          load_done <= 1'b1; // held until next reset
        end
        default: state <= LD_IDLE;
      endcase
    end
  end
endmodule : fuse_loader
`default_nettype wire

// [hdl/otp_cfg_pkg.sv]
// constants shared by the fuse-backed configuration bank
package otp_cfg_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_SYS_CFG = 8'h29;
  localparam logic [7:0] IDX_FS_SYS_CFG = 8'h2A;
  localparam logic [7:0] IDX_THR_A = 8'h2B;
  localparam logic [7:0] IDX_THR_B = 8'h2C;
  localparam logic [7:0] IDX_THR_C = 8'h2D;
  localparam logic [7:0] IDX_UV_DGLT = 8'h2E;
  localparam logic [7:0] IDX_OV_DGLT = 8'h2F;
  localparam logic [7:0] IDX_RST_IMPACT = 8'h30;
  localparam logic [7:0] IDX_SPREAD_CTRL = 8'h31;
  localparam logic [7:0] IDX_STATUS = 8'h32;
  // ==========================================================
  // fuse image size
  localparam int FUSE_WORDS = 8;
  localparam logic [3:0] FUSE_LAST = 4'h7;
  // ==========================================================
  // field positions in the system configuration word
  localparam int SHAPE_BIT = 1;
  localparam int SPREAD_EN_BIT = 2;
  localparam int SLOT_SKIP_BIT = 3;
  localparam int CHK_DIS_BIT = 4;
  localparam int CHK_DBG_DIS_BIT = 5;
  localparam int CHK_INV_BIT = 6;
  // field values
  localparam logic SHAPE_TRIANGLE = 1'b0;
  localparam logic SHAPE_RANDOM = 1'b1;
  // status fields
  localparam int STAT_LOADED_BIT = 0;
  localparam int STAT_ERRCNT_LSB = 8;
  // ==========================================================
  // reset values and frame check constants
  localparam logic [7:0] FUSE_RESET = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_XOR_INV = 8'hFF;
  localparam logic [7:0] CRC_XOR_PLAIN = 8'h00;
  // ==========================================================
  // loader states
  typedef enum logic [3:0] {
    LD_IDLE = 4'b0001,
    LD_REQ = 4'b0010,
    LD_WAIT = 4'b0100,
    LD_DONE = 4'b1000
  } load_state_t;
endpackage : otp_cfg_pkg

// [hdl/otp_config_bank.sv]
// fuse-backed configuration bank with apb access and frame check
`timescale 1ns/1ps
`default_nettype none
module otp_config_bank
  import otp_cfg_pkg::*;
(
  input wire logic clk_sys, // system clock, 50 MHz
  input wire logic nrst, // async reset, active low
  input wire logic [9:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic fuse_req, // fuse array request
  output logic [3:0] fuse_idx, // fuse word index
  input wire logic [7:0] fuse_rdata, // fuse word
  input wire logic fuse_ack, // fuse word valid
  input wire logic debug_mode, // device in debug mode
  input wire logic frame_start, // new serial frame
  input wire logic [7:0] frame_byte, // frame byte
  input wire logic frame_byte_valid, // frame byte strobe
  input wire logic [7:0] frame_rx_crc, // received check byte
  input wire logic frame_check, // compare strobe
  output logic [7:0] crc_tx, // check byte to send
  output logic crc_error, // mismatch pulse
  output logic spread_enable, // clock spreading on
  output logic spread_shape, // 1 random, 0 triangle
  output logic slot_skip, // sequencer may skip slots
  output logic load_done // fuse image loaded
);
  logic [7:0] fuse_reg [FUSE_WORDS];
  logic load_we;
  logic [3:0] load_idx;
  logic [7:0] load_data;
  logic loaded;
  logic [7:0] crc_raw;
  logic crc_on;
  logic [7:0] err_count;
  logic [7:0] sys_cfg;
  logic [7:0] reg_idx;
  logic in_fuse;
  logic access;
  logic [7:0] fuse_sel;

  assign sys_cfg = fuse_reg[0];

  // ==========================================================
  // fuse image loader
  fuse_loader u_loader (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .fuse_req(fuse_req),
    .fuse_idx(fuse_idx),
    .fuse_rdata(fuse_rdata),
    .fuse_ack(fuse_ack),
    .load_we(load_we),
    .load_idx(load_idx),
    .load_data(load_data),
    .load_done(loaded)
  );

  // fuse words: written only by the loader
  generate
    for (genvar g = 0; g < FUSE_WORDS; g++)
    begin : g_fuse
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
          fuse_reg[g] <= FUSE_RESET;
        else if (load_we && load_idx == 4'(g))
          fuse_reg[g] <= load_data;
      end
    end
  endgenerate

  // ==========================================================
  // boot defaults toward clock generator and sequencer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      spread_shape <= SHAPE_TRIANGLE;
      slot_skip <= 1'b0;
      load_done <= 1'b0;
    end
    else
    begin
      load_done <= loaded;
      spread_shape <= sys_cfg[SHAPE_BIT] ? SHAPE_RANDOM
                                          : SHAPE_TRIANGLE;
      slot_skip <= sys_cfg[SLOT_SKIP_BIT];
    end
  end

  // spreading: fuse default at boot, software may change it later
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      spread_enable <= 1'b0;
    else if (loaded && !load_done)
      spread_enable <= sys_cfg[SPREAD_EN_BIT];
    else if (access && pwrite && reg_idx == IDX_SPREAD_CTRL)
      spread_enable <= pwdata[0];
  end

  // ==========================================================
  // frame check control
  always_comb
  begin
    if (debug_mode)
      crc_on = !sys_cfg[CHK_DBG_DIS_BIT] && sys_cfg[CHK_DIS_BIT];
    else
      crc_on = !sys_cfg[CHK_DIS_BIT];
  end

  frame_crc8 u_crc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(frame_start),
    .data(frame_byte),
    .valid(frame_byte_valid),
    .invert(sys_cfg[CHK_INV_BIT]),
    .active(crc_on),
    .crc_raw(crc_raw),
    .crc_tx(crc_tx)
  );

  // compare received byte; no monitoring while check is off
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      crc_error <= 1'b0;
    else
      crc_error <= frame_check && crc_on
                   && (frame_rx_crc != crc_tx);
  end

  // saturating mismatch count for the status word
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      err_count <= 8'h00;
    else if (crc_error && err_count != 8'hFF)
      err_count <= err_count + 8'h01;
  end

  // ==========================================================
  // apb slave: one wait state, registered answer
  assign reg_idx = paddr[9:2];
  assign access = psel && penable && pready;
  assign in_fuse = reg_idx >= IDX_SYS_CFG && reg_idx <= IDX_RST_IMPACT;
  assign fuse_sel = fuse_reg[3'(reg_idx - IDX_SYS_CFG)];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready)
      begin
        if (pwrite)
          pslverr <= reg_idx != IDX_SPREAD_CTRL;
        else if (in_fuse)
          prdata <= {24'h00_0000, fuse_sel};
        else if (reg_idx == IDX_SPREAD_CTRL)
          prdata <= {31'h0, spread_enable};
        else if (reg_idx == IDX_STATUS)
          prdata <= {16'h0000, err_count, 7'h00, load_done};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_shape_random;
    load_done && sys_cfg[SHAPE_BIT] |-> spread_shape == SHAPE_RANDOM;
  endproperty
  a_shape_random: assert property (p_shape_random)
    else $error("random shape not selected");

  property p_shape_tri;
    load_done && !sys_cfg[SHAPE_BIT] |-> spread_shape == SHAPE_TRIANGLE;
  endproperty
  a_shape_tri: assert property (p_shape_tri)
    else $error("triangle shape not selected");

  property p_spread_boot;
    $rose(load_done) |-> spread_enable == sys_cfg[SPREAD_EN_BIT];
  endproperty
  a_spread_boot: assert property (p_spread_boot)
    else $error("spreading boot state wrong");

  property p_slot_skip;
    load_done |-> slot_skip == sys_cfg[SLOT_SKIP_BIT];
  endproperty
  a_slot_skip: assert property (p_slot_skip)
    else $error("slot skip differs from fuse");

  property p_mismatch;
    frame_check && crc_on && frame_rx_crc != crc_tx |=> crc_error;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("mismatch not flagged");

  property p_off_zero;
    !crc_on ##1 !crc_on |-> crc_tx == 8'h00 && !crc_error;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("check slot not zero while off");

  property p_debug_off;
    debug_mode && sys_cfg[CHK_DBG_DIS_BIT] |-> !crc_on;
  endproperty
  a_debug_off: assert property (p_debug_off)
    else $error("check active in debug mode");

  property p_final_xor;
    crc_on |=> crc_tx == ($past(crc_raw)
      ^ ($past(sys_cfg[CHK_INV_BIT]) ? CRC_XOR_INV : CRC_XOR_PLAIN));
  endproperty
  a_final_xor: assert property (p_final_xor)
    else $error("final xor wrong");

  property p_read_only;
    psel && penable && !pready && pwrite && in_fuse |=> pready && pslverr;
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("fuse write not refused");

  property p_fuse_stable;
    load_done |=> $stable(sys_cfg);
  endproperty
  a_fuse_stable: assert property (p_fuse_stable)
    else $error("fuse word changed after load");

  property p_loader_only;
    !load_we |=> $stable(sys_cfg);
  endproperty
  a_loader_only: assert property (p_loader_only)
    else $error("fuse word changed without loader");

  property p_read_data;
    psel && penable && !pready && !pwrite && in_fuse
      |=> pready && !pslverr && prdata == {24'h00_0000, $past(fuse_sel)};
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("fuse word read wrong");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");

  property p_spread_sw;
    load_done && !(access && pwrite && reg_idx == IDX_SPREAD_CTRL)
      |=> $stable(spread_enable);
  endproperty
  a_spread_sw: assert property (p_spread_sw)
    else $error("spreading changed without a write");

  property p_match_quiet;
    frame_check && frame_rx_crc == crc_tx |=> !crc_error;
  endproperty
  a_match_quiet: assert property (p_match_quiet)
    else $error("matching check byte flagged");

  property p_error_off;
    !crc_on |=> !crc_error;
  endproperty
  a_error_off: assert property (p_error_off)
    else $error("mismatch flagged while check off");

  property p_debug_on;
    debug_mode && !sys_cfg[CHK_DBG_DIS_BIT]
      |-> crc_on == sys_cfg[CHK_DIS_BIT];
  endproperty
  a_debug_on: assert property (p_debug_on)
    else $error("debug check state wrong");

  c_load: cover property ($rose(load_done));
  c_error: cover property (crc_error);
  c_debug: cover property (debug_mode && crc_on && frame_check);
  c_refused: cover property (pready && pslverr);
endmodule : otp_config_bank
`default_nettype wire

// [testbench/otp_config_bank_tb_top.sv]
// self-checking bench for the fuse-backed configuration bank
`timescale 1ns/1ps
`default_nettype none
module otp_config_bank_tb_top;
  import otp_cfg_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic fuse_req, debug_mode, frame_start, frame_byte_valid, frame_check;
  logic fuse_ack = 1'b0;
  logic [3:0] fuse_idx;
  logic [7:0] fuse_rdata, frame_byte, frame_rx_crc, crc_tx, cfg;
  logic crc_error, spread_enable, spread_shape, slot_skip, load_done;
  logic [7:0] imgs [3] = '{8'h0E, 8'h50, 8'h70};
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  int exp_errs = 0;

  otp_config_bank dut (
    .clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse_req(fuse_req),
    .fuse_idx(fuse_idx), .fuse_rdata(fuse_rdata), .fuse_ack(fuse_ack),
    .debug_mode(debug_mode), .frame_start(frame_start),
    .frame_byte(frame_byte), .frame_byte_valid(frame_byte_valid),
    .frame_rx_crc(frame_rx_crc), .frame_check(frame_check),
    .crc_tx(crc_tx), .crc_error(crc_error), .spread_enable(spread_enable),
    .spread_shape(spread_shape), .slot_skip(slot_skip),
    .load_done(load_done)
  );

  // ==========================================================
  // clock, timeout and fuse array stand-in
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // cut a hang short after a generous cycle budget
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // fuse array answers one cycle after each request, word k = cfg ^ 25h*k
  always @(posedge clk_sys)
  begin
    fuse_ack <= fuse_req && !fuse_ack;
    fuse_rdata <= cfg ^ 8'(8'h25 * fuse_idx);
  end

  // ==========================================================
  // shared tasks
  task chk(input string what, input logic [31:0] got,
           input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task test_done();
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // msb-first remainder over two bytes
  function automatic logic [7:0] crc_of(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = (c << 1) ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc_of

  // one apb transfer: setup, access, wait for ready
  task apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ==========================================================
  // scenarios
  task boot(input logic [7:0] img);
    exp_errs = 0;
    cfg <= img;
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    while (load_done !== 1'b1)
      @(posedge clk_sys);
    chk("spread_shape", 32'(spread_shape), 32'(img[SHAPE_BIT]));
    chk("spread_enable", 32'(spread_enable), 32'(img[SPREAD_EN_BIT]));
    chk("slot_skip", 32'(slot_skip), 32'(img[SLOT_SKIP_BIT]));
  endtask : boot

  task regs_scn(input logic [7:0] img);
    logic [31:0] rd;
    logic er;
    for (int k = 0; k < FUSE_WORDS; k++)
    begin
      apb(IDX_SYS_CFG + 8'(k), 1'b0, 32'h0, rd, er);
      chk("fuse word", rd, {24'h0, img ^ 8'(8'h25 * k)});
      chk("fuse word err", 32'(er), 32'h0);
    end
    apb(IDX_FS_SYS_CFG, 1'b1, 32'hFFFFFFFF, rd, er);
    chk("fuse write err", 32'(er), 32'h1);
    apb(IDX_FS_SYS_CFG, 1'b0, 32'h0, rd, er);
    chk("fuse after write", rd, {24'h0, img ^ 8'h25});
    apb(8'hC0, 1'b0, 32'h0, rd, er);
    chk("unmapped err", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(IDX_STATUS, 1'b0, 32'h0, rd, er);
    chk("status loaded", 32'(rd[STAT_LOADED_BIT]), 32'h1);
    apb(IDX_SPREAD_CTRL, 1'b1, {31'h0, ~img[SPREAD_EN_BIT]}, rd, er);
    chk("spread ctrl err", 32'(er), 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("spread after write", 32'(spread_enable),
        32'(!img[SPREAD_EN_BIT]));
    apb(IDX_SPREAD_CTRL, 1'b0, 32'h0, rd, er);
    chk("spread ctrl read", rd, 32'(!img[SPREAD_EN_BIT]));
  endtask : regs_scn

  // mismatch count in the status word, cleared by reset
  task err_scn();
    logic [31:0] rd;
    logic er;
    apb(IDX_STATUS, 1'b0, 32'h0, rd, er);
    chk("error count", 32'(rd[STAT_ERRCNT_LSB +: 8]), 32'(exp_errs));
  endtask : err_scn

  task frame_scn(input logic [7:0] img, input logic dbg, input logic bad);
    logic act;
    logic [7:0] exp;
    act = dbg ? (!img[CHK_DBG_DIS_BIT] && img[CHK_DIS_BIT])
              : !img[CHK_DIS_BIT];
    exp = crc_of(16'hA53C);
    exp = exp ^ (img[CHK_INV_BIT] ? CRC_XOR_INV : CRC_XOR_PLAIN);
    exp = act ? exp : 8'h00;
    debug_mode <= dbg;
    frame_start <= 1'b1;
    @(posedge clk_sys);
    frame_start <= 1'b0;
    frame_byte <= 8'hA5;
    frame_byte_valid <= 1'b1;
    @(posedge clk_sys);
    frame_byte <= 8'h3C;
    @(posedge clk_sys);
    frame_byte_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("crc_tx", 32'(crc_tx), 32'(exp));
    frame_rx_crc <= bad ? ~exp : exp;
    frame_check <= 1'b1;
    @(posedge clk_sys);
    frame_check <= 1'b0;
    @(posedge clk_sys);
    chk("crc_error", 32'(crc_error), 32'(act && bad));
    if (act && bad)
      exp_errs++;
  endtask : frame_scn

  // ==========================================================
  // main sequence
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    cfg = 8'h00;
    debug_mode = 1'b0;
    frame_start = 1'b0;
    frame_byte = 8'h00;
    frame_byte_valid = 1'b0;
    frame_rx_crc = 8'h00;
    frame_check = 1'b0;
    foreach (imgs[i])
    begin
      boot(imgs[i]);
      regs_scn(imgs[i]);
      for (int m = 0; m < 4; m++)
        frame_scn(imgs[i], m[1], m[0]);
      err_scn();
    end
    test_done();
  end
endmodule : otp_config_bank_tb_top
`default_nettype wire
